// [include/ncq_nd_pkg.sv]
// Constants and carriers for the queued non-data command handler.
// Assumes a 32-tag queue and a one-clock link layer in front of it.
package ncq_nd_pkg;
  localparam int TAGW = 5;
  localparam int ACTW = 32;
  // Subcommand codes
  localparam logic [3:0] SUB_ABORT    = 4'h0;
  localparam logic [3:0] SUB_DEADLINE = 4'h1;
  localparam logic [3:0] SUB_SETFEAT  = 4'h5;
  // Abort type codes
  localparam logic [3:0] AT_ALL       = 4'h0;
  localparam logic [3:0] AT_STREAM    = 4'h1;
  localparam logic [3:0] AT_NONSTREAM = 4'h2;
  localparam logic [3:0] AT_SELECT    = 4'h3;
  // Status and error bytes
  localparam logic [7:0] ST_OK        = 8'h40;
  localparam logic [7:0] ST_ERR       = 8'h41;
  localparam logic [7:0] ERR_ABRT     = 8'h04;
  // Logs
  localparam logic [7:0]  LOG_PAGE    = 8'h12;
  localparam logic [7:0]  DIR_PAGE    = 8'h00;
  localparam logic [15:0] GPL_VER     = 16'h0001;
  localparam logic [15:0] LOG_PAGES   = 16'h0001;
  localparam logic [6:0]  DIR_DW_LOG  = 7'h09;
  localparam logic [6:0]  DW_ABORT    = 7'h00;
  localparam logic [6:0]  DW_DEADLINE = 7'h01;
  localparam logic [6:0]  DW_SETFEAT  = 7'h05;
  localparam int          ID_W77_BIT  = 5;
  // Register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_FLAGS    = 8'h04;
  localparam logic [7:0] REG_PEND     = 8'h08;
  localparam logic [7:0] REG_DONE     = 8'h0C;
  localparam int         CTRL_NCQEN   = 0;
  localparam logic       CTRL_RST     = 1'b1;
  localparam int         FLG_WR_NC    = 0;
  localparam int         FLG_RD_NC    = 1;

  typedef struct packed {
    logic [TAGW-1:0] tag;
    logic [3:0]      sub;
    logic [3:0]      abortType;
    logic [TAGW-1:0] targetTag;
    logic            writeNoContinue;
    logic            readNoContinue;
  } cmd_t;

  typedef struct packed {
    logic            sdb;
    logic            intr;
    logic [7:0]      status;
    logic [7:0]      error;
    logic [ACTW-1:0] act;
  } fis_t;
endpackage : ncq_nd_pkg

// [design/ncq_log_rom.sv]
// Capability log page and log directory reader.
// Assumes a one-cycle read strobe; data stand in the next cycle.
`timescale 1ns/10ps
module ncq_log_rom (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Capabilities
  input  wire logic [4:0]  capAbort,
  input  wire logic [2:0]  capDeadline,
  input  wire logic        capSetFeat,
  // Read port
  input  wire logic        logRd,
  input  wire logic [7:0]  logPage,
  input  wire logic [6:0]  logDw,
  output logic      [31:0] logData
);
  typedef struct packed {
    logic [31:0] data;
  } rom_st_t;

  rom_st_t q;
  rom_st_t nxt_q;

  always_comb begin
    nxt_q = q;
    if (logRd) begin
      nxt_q.data = 32'h0;
      if (logPage == ncq_nd_pkg::DIR_PAGE) begin
        if (logDw == 7'h00) begin
          nxt_q.data = {16'h0, ncq_nd_pkg::GPL_VER};
        end else if (logDw == ncq_nd_pkg::DIR_DW_LOG) begin
          nxt_q.data = {16'h0, ncq_nd_pkg::LOG_PAGES};
        end
      end else if (logPage == ncq_nd_pkg::LOG_PAGE) begin
        case (logDw)
          ncq_nd_pkg::DW_ABORT:    nxt_q.data = {27'h0, capAbort};
          ncq_nd_pkg::DW_DEADLINE: nxt_q.data = {29'h0, capDeadline};
          ncq_nd_pkg::DW_SETFEAT:  nxt_q.data = {31'h0, capSetFeat};
          default:                 nxt_q.data = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign logData = q.data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_log_ver;
    logRd && logPage == ncq_nd_pkg::DIR_PAGE && logDw == 7'h00
      |=> logData == 32'h0000_0001;
  endproperty
  a_log_ver: assert property (p_log_ver) else $error("log version word wrong");

  property p_log_resv;
    logRd && logPage == ncq_nd_pkg::LOG_PAGE && logDw > 7'h05
      |=> logData == 32'h0;
  endproperty
  a_log_resv: assert property (p_log_resv) else $error("reserved log dword not zero");
endmodule : ncq_log_rom

// [design/ncq_nondata_handler.sv]
// Queued non-data command handler: abort, deadline handling, set features.
// Assumes the link layer delivers commands and completions on clk.
//
// Summary of operation
// - Subcommand 0h aborts queue, handled immediately.
// - Abort touches only commands accepted earlier.
// - Supported abort type with valid target tag reports success.
// - One SDB sets own and aborted tags.
// - Abort refused: no queuing, self, bad tag, type.
// - Subcommand 1h sets streaming deadline handling.
// - No-continue flags survive soft reset only.
// - Deadline handling completes by clean SDB.
// - Deadline handling refused while queuing disabled.
// - Subcommand 5h runs a queued set features.
// - Completions send SDB, interrupt, clean status.
// - Early errors send register FIS with ERR.
// - Capability log 12h, version word 0001h.
// - Log dword 0 lists abort type support.
// - Log dword 1 lists deadline flag support.
// - Log dword 5 set features; rest zero.
// - Abort type accepted only if capability set.
// - Identify word 77 bit 5 flags support.
// - Command while queuing disabled is aborted.
// - Bad subcommand aborts it and whole queue.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module ncq_nondata_handler #(
  parameter int unsigned NTAGS       = 32,
  parameter logic [4:0]  CAP_ABORT   = 5'h1F,
  parameter logic [2:0]  CAP_DEADLN  = 3'h7,
  parameter logic        CAP_SETFEAT = 1'b1
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   softRst,
  // Command from link
  input  wire logic                   cmdValid,
  input  wire ncq_nd_pkg::cmd_t       cmd,
  // Queue engine events
  input  wire logic                   accValid,
  input  wire logic [4:0]             accTag,
  input  wire logic                   accStream,
  input  wire logic                   doneValid,
  input  wire logic [4:0]             doneTag,
  // FIS to link
  output logic                        fisValid,
  output ncq_nd_pkg::fis_t            fis,
  // Abort to queue engine
  output logic                        abortValid,
  output logic [31:0]                 abortMask,
  // Set features engine
  output logic                        sfReq,
  output ncq_nd_pkg::cmd_t            sfCmd,
  input  wire logic                   sfDone,
  input  wire logic                   sfErr,
  input  wire logic [7:0]             sfErrCode,
  // Streaming flags
  output logic                        writeNoContinue,
  output logic                        readNoContinue,
  // Register port
  input  wire logic [7:0]             regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [31:0]            regRdata,
  // Log read port and identify word
  input  wire logic                   logRd,
  input  wire logic [7:0]             logPage,
  input  wire logic [6:0]             logDw,
  output logic      [31:0]            logData,
  output logic      [15:0]            idW77
);
  typedef enum logic {IDLE, SF_WAIT} state_t;

  typedef struct packed {
    state_t           state;
    logic             ncqEn;
    logic             wrNc;
    logic             read_no_continue_flag;
    logic [31:0]      pend;
    logic [31:0]      strm;
    logic [31:0]      doneAcc;
    logic [4:0]       ownTag;
    logic             fisValid;
    ncq_nd_pkg::fis_t fis;
    logic             abortValid;
    logic [31:0]      abortMask;
    logic             sfReq;
    ncq_nd_pkg::cmd_t sfCmd;
    logic [31:0]      rdata;
  } st_t;

  st_t q;
  st_t nxt_q;

  function automatic logic [31:0] oneHot(input logic [4:0] t);
    return 32'h1 << t;
  endfunction : oneHot

  function automatic logic tagOk(input logic [4:0] t);
    return 32'(t) < NTAGS;
  endfunction : tagOk

  function automatic ncq_nd_pkg::fis_t mkSdb(input logic [31:0] act);
    ncq_nd_pkg::fis_t f;
    f.sdb    = 1'b1;
    f.intr   = 1'b1;
    f.status = ncq_nd_pkg::ST_OK;
    f.error  = 8'h00;
    f.act    = act;
    return f;
  endfunction : mkSdb

  function automatic ncq_nd_pkg::fis_t mkRegErr(input logic [7:0] code);
    ncq_nd_pkg::fis_t f;
    f.sdb    = 1'b0;
    f.intr   = 1'b1;
    f.status = ncq_nd_pkg::ST_ERR;
    f.error  = code;
    f.act    = 32'h0;
    return f;
  endfunction : mkRegErr

  // Abort type support follows capability bits 1..4
  function automatic logic typeOk(input logic [3:0] at);
    case (at)
      ncq_nd_pkg::AT_ALL:       return CAP_ABORT[1];
      ncq_nd_pkg::AT_STREAM:    return CAP_ABORT[2];
      ncq_nd_pkg::AT_NONSTREAM: return CAP_ABORT[3];
      ncq_nd_pkg::AT_SELECT:    return CAP_ABORT[4];
      default:                  return 1'b0;
    endcase
  endfunction : typeOk

  logic        abortBad;
  logic [31:0] abortSet;

  always_comb begin
    abortBad = !q.ncqEn || !CAP_ABORT[0] || cmd.targetTag == cmd.tag
               || !tagOk(cmd.targetTag) || !typeOk(cmd.abortType);
    case (cmd.abortType)
      ncq_nd_pkg::AT_STREAM:    abortSet = q.pend & q.strm;
      ncq_nd_pkg::AT_NONSTREAM: abortSet = q.pend & ~q.strm;
      ncq_nd_pkg::AT_SELECT:    abortSet = q.pend & oneHot(cmd.targetTag);
      default:                  abortSet = q.pend;
    endcase
  end

  always_comb begin
    nxt_q            = q;
    nxt_q.fisValid   = 1'b0;
    nxt_q.abortValid = 1'b0;
    nxt_q.abortMask  = 32'h0;
    nxt_q.sfReq      = 1'b0;
    if (accValid) begin
      nxt_q.pend[accTag] = 1'b1;
      nxt_q.strm[accTag] = accStream;
    end
    case (q.state)
      IDLE: begin
        if (cmdValid) begin
          nxt_q.ownTag = cmd.tag;
          nxt_q.fisValid = 1'b1;
          if (!q.ncqEn) begin
            nxt_q.fis = mkRegErr(ncq_nd_pkg::ERR_ABRT);
          end else begin
            case (cmd.sub)
              ncq_nd_pkg::SUB_ABORT: begin
                if (abortBad) begin
                  nxt_q.fis = mkRegErr(ncq_nd_pkg::ERR_ABRT);
                end else begin
                  // Immediate: snapshot of earlier acceptances only
                  nxt_q.pend       = nxt_q.pend & ~abortSet;
                  nxt_q.abortValid = 1'b1;
                  nxt_q.abortMask  = abortSet;
                  nxt_q.fis = mkSdb(q.doneAcc | abortSet | oneHot(cmd.tag));
                  nxt_q.doneAcc = 32'h0;
                end
              end
              ncq_nd_pkg::SUB_DEADLINE: begin
                if (!CAP_DEADLN[0]) begin
                  nxt_q.fis = mkRegErr(ncq_nd_pkg::ERR_ABRT);
                end else begin
                  if (CAP_DEADLN[1]) begin
                    nxt_q.wrNc = cmd.writeNoContinue;
                  end
                  if (CAP_DEADLN[2]) begin
                    nxt_q.read_no_continue_flag = cmd.readNoContinue;
                  end
                  nxt_q.fis = mkSdb(q.doneAcc | oneHot(cmd.tag));
                  nxt_q.doneAcc = 32'h0;
                end
              end
              ncq_nd_pkg::SUB_SETFEAT: begin
                if (!CAP_SETFEAT) begin
                  nxt_q.fis = mkRegErr(ncq_nd_pkg::ERR_ABRT);
                end else begin
                  nxt_q.fisValid = 1'b0;
                  nxt_q.sfReq    = 1'b1;
                  nxt_q.sfCmd    = cmd;
                  nxt_q.state    = SF_WAIT;
                end
              end
              default: begin
                nxt_q.fis        = mkRegErr(ncq_nd_pkg::ERR_ABRT);
                nxt_q.abortValid = 1'b1;
                nxt_q.abortMask  = q.pend;
                nxt_q.pend       = nxt_q.pend & ~q.pend;
              end
            endcase
          end
        end else if (q.doneAcc != 32'h0) begin
          nxt_q.fisValid = 1'b1;
          nxt_q.fis      = mkSdb(q.doneAcc);
          nxt_q.doneAcc  = 32'h0;
        end
      end
      SF_WAIT: begin
        if (sfDone) begin
          nxt_q.fisValid = 1'b1;
          nxt_q.state    = IDLE;
          if (sfErr) begin
            nxt_q.fis = mkRegErr(sfErrCode);
          end else begin
            nxt_q.fis     = mkSdb(q.doneAcc | oneHot(q.ownTag));
            nxt_q.doneAcc = 32'h0;
          end
        end
      end
      default: nxt_q.state = IDLE;
    endcase
    // Completion set wins over the clear above
    if (doneValid) begin
      nxt_q.doneAcc[doneTag] = 1'b1;
      nxt_q.pend[doneTag]    = 1'b0;
    end
    if (regWr) begin
      case (regAddr)
        ncq_nd_pkg::REG_CTRL: nxt_q.ncqEn = regWdata[ncq_nd_pkg::CTRL_NCQEN];
        ncq_nd_pkg::REG_FLAGS: begin
          nxt_q.wrNc = regWdata[ncq_nd_pkg::FLG_WR_NC];
          nxt_q.read_no_continue_flag = regWdata[ncq_nd_pkg::FLG_RD_NC];
        end
        default: ;
      endcase
    end
    nxt_q.rdata = 32'h0;
    if (regRd) begin
      case (regAddr)
        ncq_nd_pkg::REG_CTRL:  nxt_q.rdata = {31'h0, q.ncqEn};
        ncq_nd_pkg::REG_FLAGS: nxt_q.rdata = {30'h0, q.read_no_continue_flag, q.wrNc};
        ncq_nd_pkg::REG_PEND:  nxt_q.rdata = q.pend;
        ncq_nd_pkg::REG_DONE:  nxt_q.rdata = q.doneAcc;
        default:               nxt_q.rdata = 32'h0;
      endcase
    end
    // Soft reset clears the queue but keeps the flags
    if (softRst) begin
      nxt_q.state      = IDLE;
      nxt_q.pend       = 32'h0;
      nxt_q.strm       = 32'h0;
      nxt_q.doneAcc    = 32'h0;
      nxt_q.fisValid   = 1'b0;
      nxt_q.abortValid = 1'b0;
      nxt_q.sfReq      = 1'b0;
      nxt_q.wrNc       = q.wrNc;
      nxt_q.read_no_continue_flag       = q.read_no_continue_flag;
    end
  end

  // Power-on reset clears the flags; otherwise only REG_FLAGS writes and subcommand 1h change them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.ncqEn <= ncq_nd_pkg::CTRL_RST;
      q.state <= IDLE;
    end else begin
      q <= nxt_q;
    end
  end

  assign fisValid        = q.fisValid;
  assign fis             = q.fis;
  assign abortValid      = q.abortValid;
  assign abortMask       = q.abortMask;
  assign sfReq           = q.sfReq;
  assign sfCmd           = q.sfCmd;
  assign writeNoContinue = q.wrNc;
  assign readNoContinue  = q.read_no_continue_flag;
  assign regRdata        = q.rdata;
  assign idW77 = 16'(CAP_ABORT[0] | CAP_DEADLN[0] | CAP_SETFEAT)
                 << ncq_nd_pkg::ID_W77_BIT;

  ncq_log_rom u_log (
    .clk         (clk),
    .rstn        (rstn),
    .capAbort    (CAP_ABORT),
    .capDeadline (CAP_DEADLN),
    .capSetFeat  (CAP_SETFEAT),
    .logRd       (logRd),
    .logPage     (logPage),
    .logDw       (logDw),
    .logData     (logData)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic idleIn;
  assign idleIn = cmdValid && q.state == IDLE && !softRst;

  property p_noncq;
    idleIn && !q.ncqEn |=> fisValid && !fis.sdb && fis.error == 8'h04;
  endproperty
  a_noncq: assert property (p_noncq) else $error("disabled queue not aborted");

  property p_abort_self;
    idleIn && q.ncqEn && cmd.sub == 4'h0 && cmd.targetTag == cmd.tag
      |=> fisValid && !fis.sdb && !abortValid;
  endproperty
  a_abort_self: assert property (p_abort_self) else $error("self abort accepted");

  property p_abort_ok;
    idleIn && q.ncqEn && cmd.sub == 4'h0 && !abortBad
      |=> fisValid && fis.sdb && fis.act[q.ownTag] && (abortMask & ~fis.act) == 32'h0;
  endproperty
  a_abort_ok: assert property (p_abort_ok) else $error("abort success wrong");

  property p_abort_scope;
    abortValid |-> (abortMask & ~$past(q.pend)) == 32'h0 && (q.pend & abortMask) == 32'h0;
  endproperty
  a_abort_scope: assert property (p_abort_scope) else $error("abort beyond earlier tags");

  property p_deadline;
    idleIn && q.ncqEn && cmd.sub == 4'h1
      |=> fisValid && fis.sdb && fis.error == 8'h00 && fis.act[q.ownTag];
  endproperty
  a_deadline: assert property (p_deadline) else $error("deadline not completed");

  property p_flags_keep;
    softRst && !regWr |=> $stable(q.wrNc) && $stable(q.read_no_continue_flag);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("flags lost on soft reset");

  property p_sdb_clean;
    fisValid && fis.sdb |-> fis.intr && fis.status == 8'h40 && fis.error == 8'h00;
  endproperty
  a_sdb_clean: assert property (p_sdb_clean) else $error("dirty completion FIS");

  property p_reg_err;
    fisValid && !fis.sdb |-> fis.status[0] && !fis.status[7] && fis.error != 8'h00;
  endproperty
  a_reg_err: assert property (p_reg_err) else $error("error FIS malformed");

  property p_bad_sub;
    idleIn && q.ncqEn && !(cmd.sub inside {4'h0, 4'h1, 4'h5})
      |=> abortValid && abortMask == $past(q.pend) && !fis.sdb;
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("bad subcommand kept queue");

  property p_setfeat;
    idleIn && q.ncqEn && cmd.sub == 4'h5 |=> sfReq ##1 !sfReq;
  endproperty
  a_setfeat: assert property (p_setfeat) else $error("set features not issued");

  c_abort: cover property (fisValid && fis.sdb && abortValid && abortMask != 32'h0);
  c_merge: cover property (doneValid ##1 fisValid && fis.sdb && $countones(fis.act) > 1);
  c_sferr: cover property (q.state == SF_WAIT && sfDone && sfErr);
endmodule : ncq_nondata_handler

// [tb/ncq_host_model.sv]
// Host side model: issues non-data commands and plays the set-features engine.
// Answers each sfReq from the handler with one sfDone pulse per request.
`timescale 1ns/10ps
module ncq_host_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Command to device
  output logic                   cmdValid,
  output ncq_nd_pkg::cmd_t       cmd,
  // Set features engine
  input  wire logic              sfReq,
  output logic                   sfDone,
  output logic                   sfErr,
  output logic [7:0]             sfErrCode
);
  logic sfFail;
  int   sfDelay;

  initial begin
    cmdValid  = 1'b0;
    cmd       = '0;
    sfDone    = 1'b0;
    sfErr     = 1'b0;
    sfErrCode = 8'h00;
    sfFail    = 1'b0;
    sfDelay   = 0;
  end

  // Never sends a queue abort as a packet device; target tag goes in its own field
  task automatic issue(input ncq_nd_pkg::cmd_t c);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd      <= c;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmd      <= ~c;
  endtask : issue

  // Error fields only mean something with sfDone; they toggle otherwise
  always @(posedge clk) begin
    if (rstn && sfReq === 1'b1) begin
      repeat (sfDelay) @(posedge clk);
      sfDone    <= 1'b1;
      sfErr     <= sfFail;
      sfErrCode <= 8'h51;
      @(posedge clk);
    end
    sfDone    <= 1'b0;
    sfErr     <= ~sfErr;
    sfErrCode <= ~sfErrCode;
  end
endmodule : ncq_host_model

// [tb/tb_top.sv]
// Self-checking bench for the queued non-data command handler.
// Assumes a 100 MHz clock and a 16-tag queue so tag 20 is out of range.
`timescale 1ns/10ps
module tb_top;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              softRst, accValid, accStream, doneValid, regWr, regRd, logRd;
  logic              cmdValid, fisValid, abortValid, sfReq, sfDone, sfErr, wnc, rnc;
  logic [4:0]        accTag, doneTag;
  logic [6:0]        logDw;
  logic [7:0]        regAddr, logPage, sfErrCode;
  logic [15:0]       idW77;
  logic [31:0]       regWdata, regRdata, logData, abortMask, gotMask, lat;
  ncq_nd_pkg::cmd_t  cmd, sfCmd;
  ncq_nd_pkg::fis_t  fis, gotFis;
  int                n_errors = 0;
  int                samples_checked = 0;

  always #5 clk = ~clk;

  ncq_nondata_handler #(.NTAGS(16)) i_dut (
    .clk(clk), .rstn(rstn), .softRst(softRst), .cmdValid(cmdValid), .cmd(cmd),
    .accValid(accValid), .accTag(accTag), .accStream(accStream), .doneValid(doneValid),
    .doneTag(doneTag), .fisValid(fisValid), .fis(fis), .abortValid(abortValid),
    .abortMask(abortMask), .sfReq(sfReq), .sfCmd(sfCmd), .sfDone(sfDone), .sfErr(sfErr),
    .sfErrCode(sfErrCode), .writeNoContinue(wnc), .readNoContinue(rnc), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .logRd(logRd),
    .logPage(logPage), .logDw(logDw), .logData(logData), .idW77(idW77));

  ncq_host_model i_host (
    .clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmd(cmd), .sfReq(sfReq),
    .sfDone(sfDone), .sfErr(sfErr), .sfErrCode(sfErrCode));

  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_fis(input logic sdb, input logic [7:0] err, input logic [31:0] act);
    ncq_nd_pkg::fis_t g;
    ncq_nd_pkg::fis_t e;
    g = gotFis;
    e = '{sdb: sdb, intr: sdb, status: sdb ? ncq_nd_pkg::ST_OK : ncq_nd_pkg::ST_ERR,
          error: err, act: act};
    if (!sdb) begin
      g.intr = 1'b0;
      g.act  = '0;
    end
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_fis

  task automatic wait_fis;
    int i;
    for (i = 0; i < 30; i++) begin
      #1;
      if (fisValid === 1'b1) break;
      @(posedge clk);
    end
    if (i == 30) begin
      n_errors++;
      stop_test();
    end
    lat     = i;
    gotFis  = fis;
    gotMask = (abortValid === 1'b1) ? abortMask : 32'h0;
    @(posedge clk);
  endtask : wait_fis

  function automatic ncq_nd_pkg::cmd_t mk(input logic [4:0] t, input logic [3:0] s,
      input logic [3:0] a, input logic [4:0] tt, input logic w, input logic r);
    mk = '{tag: t, sub: s, abortType: a, targetTag: tt, writeNoContinue: w, readNoContinue: r};
  endfunction : mk

  task automatic acc(input logic [4:0] t, input logic s);
    @(posedge clk);
    accValid  <= 1'b1;
    accTag    <= t;
    accStream <= s;
    @(posedge clk);
    accValid  <= 1'b0;
    accTag    <= ~t;
  endtask : acc

  task automatic done(input logic [4:0] t);
    @(posedge clk);
    doneValid <= 1'b1;
    doneTag   <= t;
    @(posedge clk);
    doneValid <= 1'b0;
    doneTag   <= ~t;
  endtask : done

  task automatic srst;
    @(posedge clk);
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
  endtask : srst

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk(regRdata, e);
  endtask : rd

  task automatic lg(input logic [7:0] p, input logic [6:0] d, input logic [31:0] e);
    @(posedge clk);
    logRd   <= 1'b1;
    logPage <= p;
    logDw   <= d;
    @(posedge clk);
    logRd   <= 1'b0;
    #1 chk(logData, e);
  endtask : lg

  task automatic t_log;
    lg(ncq_nd_pkg::LOG_PAGE, ncq_nd_pkg::DW_ABORT, 32'h0000001F);
    lg(ncq_nd_pkg::LOG_PAGE, ncq_nd_pkg::DW_DEADLINE, 32'h00000007);
    lg(ncq_nd_pkg::LOG_PAGE, ncq_nd_pkg::DW_SETFEAT, 32'h00000001);
    lg(ncq_nd_pkg::LOG_PAGE, 7'h02, 32'h00000000);
    lg(ncq_nd_pkg::LOG_PAGE, 7'h7F, 32'h00000000);
    lg(ncq_nd_pkg::DIR_PAGE, 7'h00, 32'h00000001);
    lg(ncq_nd_pkg::DIR_PAGE, ncq_nd_pkg::DIR_DW_LOG, 32'h00000001);
    chk({31'h0, idW77[ncq_nd_pkg::ID_W77_BIT]}, 32'h00000001);
    $display("test log done");
  endtask : t_log

  task automatic t_abort;
    logic [31:0] m;
    for (int a = 0; a < 4; a++) begin
      m = (a == 0) ? 32'h0000000C : ((a == 1) ? 32'h00000004 : 32'h00000008);
      srst();
      acc(5'h02, 1'b1);
      acc(5'h03, 1'b0);
      i_host.issue(mk(5'h01, ncq_nd_pkg::SUB_ABORT, a[3:0], 5'h03, 1'b0, 1'b0));
      wait_fis();
      chk(lat, 32'h0);
      chk_fis(1'b1, 8'h00, 32'h00000002 | m);
      chk(gotMask, m);
      acc(5'h05, 1'b0);
      rd(ncq_nd_pkg::REG_PEND, (32'h0000000C & ~m) | 32'h00000020);
    end
    $display("test abort done");
  endtask : t_abort

  task automatic t_abort_err;
    for (int k = 0; k < 3; k++) begin
      i_host.issue(mk(5'h04, ncq_nd_pkg::SUB_ABORT, (k == 2) ? 4'h4 : ncq_nd_pkg::AT_ALL,
                      (k == 0) ? 5'h04 : ((k == 1) ? 5'h14 : 5'h01), 1'b0, 1'b0));
      wait_fis();
      chk_fis(1'b0, ncq_nd_pkg::ERR_ABRT, 32'h0);
      chk(gotMask, 32'h0);
    end
    i_host.issue(mk(5'h04, ncq_nd_pkg::SUB_ABORT, ncq_nd_pkg::AT_SELECT, 5'h07, 1'b0, 1'b0));
    wait_fis();
    chk_fis(1'b1, 8'h00, 32'h00000010);
    chk(gotMask, 32'h0);
    $display("test abort errors done");
  endtask : t_abort_err

  task automatic t_badsub;
    srst();
    for (int s = 2; s < 16; s++) begin
      if (s == 5) continue;
      acc(5'h08, 1'b0);
      i_host.issue(mk(5'h06, s[3:0], 4'h0, 5'h01, 1'b0, 1'b0));
      wait_fis();
      chk_fis(1'b0, ncq_nd_pkg::ERR_ABRT, 32'h0);
      chk(gotMask, 32'h00000100);
    end
    $display("test bad subcommand done");
  endtask : t_badsub

  task automatic t_deadline;
    i_host.issue(mk(5'h0A, ncq_nd_pkg::SUB_DEADLINE, 4'h0, 5'h00, 1'b1, 1'b0));
    wait_fis();
    chk_fis(1'b1, 8'h00, 32'h00000400);
    chk({30'h0, wnc, rnc}, 32'h00000002);
    rd(ncq_nd_pkg::REG_FLAGS, 32'h00000001);
    srst();
    #1 chk({30'h0, wnc, rnc}, 32'h00000002);
    i_host.issue(mk(5'h0A, ncq_nd_pkg::SUB_DEADLINE, 4'h0, 5'h00, 1'b0, 1'b1));
    wait_fis();
    chk({30'h0, wnc, rnc}, 32'h00000001);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1 chk({30'h0, wnc, rnc}, 32'h00000000);
    $display("test deadline done");
  endtask : t_deadline

  task automatic t_setfeat;
    i_host.sfFail  = 1'b0;
    i_host.sfDelay = 0;
    i_host.issue(mk(5'h0B, ncq_nd_pkg::SUB_SETFEAT, 4'h0, 5'h00, 1'b0, 1'b0));
    wait_fis();
    chk_fis(1'b1, 8'h00, 32'h00000800);
    chk(32'(sfCmd), 32'(mk(5'h0B, ncq_nd_pkg::SUB_SETFEAT, 4'h0, 5'h00, 1'b0, 1'b0)));
    i_host.sfFail  = 1'b1;
    i_host.sfDelay = 4;
    i_host.issue(mk(5'h0C, ncq_nd_pkg::SUB_SETFEAT, 4'h0, 5'h00, 1'b0, 1'b0));
    wait_fis();
    chk_fis(1'b0, 8'h51, 32'h0);
    $display("test set features done");
  endtask : t_setfeat

  task automatic t_done;
    srst();
    acc(5'h03, 1'b0);
    acc(5'h0D, 1'b1);
    done(5'h03);
    wait_fis();
    chk_fis(1'b1, 8'h00, 32'h00000008);
    done(5'h0D);
    wait_fis();
    chk_fis(1'b1, 8'h00, 32'h00002000);
    rd(ncq_nd_pkg::REG_DONE, 32'h0);
    rd(ncq_nd_pkg::REG_PEND, 32'h0);
    $display("test completions done");
  endtask : t_done

  task automatic t_ncqoff;
    logic [3:0] subs [3];
    subs = '{ncq_nd_pkg::SUB_ABORT, ncq_nd_pkg::SUB_DEADLINE, ncq_nd_pkg::SUB_SETFEAT};
    wr(ncq_nd_pkg::REG_CTRL, 32'h0);
    rd(ncq_nd_pkg::REG_CTRL, 32'h0);
    for (int k = 0; k < 3; k++) begin
      i_host.issue(mk(5'h02, subs[k], ncq_nd_pkg::AT_ALL, 5'h03, 1'b0, 1'b0));
      wait_fis();
      chk_fis(1'b0, ncq_nd_pkg::ERR_ABRT, 32'h0);
    end
    wr(ncq_nd_pkg::REG_CTRL, 32'h00000001);
    rd(ncq_nd_pkg::REG_CTRL, 32'h00000001);
    rd(8'h10, 32'h0);
    $display("test queuing off done");
  endtask : t_ncqoff

  initial begin
    {softRst, accValid, accStream, doneValid, regWr, regRd, logRd} = '0;
    {accTag, doneTag, logDw, regAddr, logPage, regWdata} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_log();
    t_abort();
    t_abort_err();
    t_badsub();
    t_deadline();
    t_setfeat();
    t_done();
    t_ncqoff();
    stop_test();
  end
endmodule : tb_top
